// ---- rtl/cdsc_top.sv ----
`timescale 1ns/1ps
module cdsc_top
    import cdsc_pkg::*;
#(
    parameter int N_OUT = NUM_OUT
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Multi-purpose control pin.
    input wire logic i_function_pin,
    // Fast clock inputs.
    input wire logic i_fast_input_one,
    input wire logic i_fast_input_two,
    // Serial control port.
    input wire logic i_scp_sclk,
    input wire logic i_scp_cs_n,
    input wire logic i_scp_sdi,
    output logic o_scp_sdo,
    output logic o_scp_sdo_oe,
    // Outputs.
    output logic [N_OUT-1:0] o_clk_out,
    output logic o_powered_down
);

    // ============================================================
    // State.
    // ============================================================
    typedef struct packed {
        logic [2:0] pin_sync; // Stage 0 and 1 synchronise; stage 2 is the previous level.
        logic [1:0] one_sync; // First fast input synchroniser.
        logic [1:0] two_sync; // Second fast input synchroniser.
        logic fast_prev; // Previous selected fast level.
        logic [2:0] sclk_sync; // Serial clock synchroniser plus previous level.
        logic [1:0] csn_sync; // Select synchroniser.
        logic [1:0] sdi_sync; // Data synchroniser.
        logic [4:0] bit_cnt; // Bits taken in this frame.
        logic [15:0] shift; // Incoming frame.
        logic [7:0] rd_shift; // Outgoing read data.
        logic sdo_oe; // Read data being driven.
        logic [7:0] sel_buf; // Buffered input select.
        logic [7:0] sel_act; // Active input select.
        logic [7:0] role_buf; // Buffered pin role.
        logic [7:0] role_act; // Active pin role.
        logic [N_OUT-1:0][7:0] cnt_buf; // Buffered divider counts.
        logic [N_OUT-1:0][7:0] cnt_act; // Active divider counts.
        logic [N_OUT-1:0][7:0] cfg_buf; // Buffered divider options.
        logic [N_OUT-1:0][7:0] cfg_act; // Active divider options.
        logic [N_OUT-1:0] clk_out; // Registered divider outputs.
        logic pd_flag; // Power-down seen.
    } cdsc_state_t;

    cdsc_state_t s_reg; // Registered state.
    cdsc_state_t s_next; // Next state.
    logic [1:0] role; // Active pin role.
    logic hard_rst_n; // Chip reset including the pin in hard reset role.
    logic pd_rst_n; // Divider reset including pin power-down.
    logic tick; // Selected fast input rising edge.
    logic fast_level; // Selected fast input level.
    logic align_rise; // Alignment rising edge.
    logic sclk_rise; // Serial clock rising edge.
    logic [15:0] frame; // Frame including the bit taken now.
    logic [N_OUT-1:0] div_out; // Divider results.

    assign role = s_reg.role_act[ROLE_LSB +: 2];

    // The pin acts without a clock, as the part must reset even with no core clock.
    // The role term comes from a register, so it cannot glitch during a frame.
    assign hard_rst_n = i_rstn & (i_function_pin | (role != ROLE_HARD_RESET));
    // Power-down clears only divider state; the registers keep their values.
    assign pd_rst_n = hard_rst_n & (i_function_pin | (role != ROLE_POWERDOWN));

    // The selected input feeds every divider; fast inputs must be slower than
    // half the core clock, since they are sampled rather than used as a clock.
    assign fast_level = s_reg.sel_act[SEL_FIRST_BIT] ? s_reg.one_sync[1] : s_reg.two_sync[1];
    assign tick = fast_level && !s_reg.fast_prev;

    // Sampled edge of the pin; after a hard reset the stages restart low,
    // so the release itself produces an alignment edge.
    assign align_rise = s_reg.pin_sync[1] && !s_reg.pin_sync[2];
    assign sclk_rise = s_reg.sclk_sync[1] && !s_reg.sclk_sync[2];
    assign frame = {s_reg.shift[14:0], s_reg.sdi_sync[1]};

    // ============================================================
    // Register read decode.
    // ============================================================
    function automatic logic [7:0] read_reg(input cdsc_state_t s, input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == ADDR_INPUT_SEL) begin
            v = s.sel_buf;
        end else if (a == ADDR_ROLE) begin
            v = s.role_buf;
        end else if (a == ADDR_STATUS) begin
            v = 8'(s.clk_out);
        end else if (a >= ADDR_DIV_FIRST && a <= ADDR_CFG_LAST) begin
            // Even offsets are counts, odd offsets are options.
            if (a[0]) begin
                v = s.cfg_buf[3'((a - ADDR_CFG_FIRST) >> 1)];
            end else begin
                v = s.cnt_buf[3'((a - ADDR_DIV_FIRST) >> 1)];
            end
        end
        return v;
    endfunction

    // ============================================================
    // Next state.
    // ============================================================
    always_comb begin
        s_next = s_reg;
        s_next.pin_sync = {s_reg.pin_sync[1:0], i_function_pin};
        s_next.one_sync = {s_reg.one_sync[0], i_fast_input_one};
        s_next.two_sync = {s_reg.two_sync[0], i_fast_input_two};
        s_next.fast_prev = fast_level;
        s_next.sclk_sync = {s_reg.sclk_sync[1:0], i_scp_sclk};
        s_next.csn_sync = {s_reg.csn_sync[0], i_scp_cs_n};
        s_next.sdi_sync = {s_reg.sdi_sync[0], i_scp_sdi};
        s_next.clk_out = div_out;
        s_next.pd_flag = (role == ROLE_POWERDOWN) && !s_reg.pin_sync[1];
        if (s_reg.csn_sync[1]) begin
            // Frame ends; drop the data line.
            s_next.bit_cnt = 5'h00;
            s_next.sdo_oe = 1'b0;
        end else if (sclk_rise && s_reg.bit_cnt != FRAME_DONE) begin
            // Extra bits past a full frame are ignored.
            s_next.shift = frame;
            s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
            s_next.rd_shift = {s_reg.rd_shift[6:0], 1'b0};
            if (s_reg.bit_cnt == ADDR_LAST_BIT && frame[7]) begin
                s_next.rd_shift = read_reg(s_reg, frame[6:0]);
                s_next.sdo_oe = 1'b1;
            end
            if (s_reg.bit_cnt == DATA_LAST_BIT && !frame[15]) begin
                // Writes land in the buffer; the update register makes them active.
                if (frame[14:8] == ADDR_INPUT_SEL) begin
                    s_next.sel_buf = frame[7:0];
                end else if (frame[14:8] == ADDR_ROLE) begin
                    s_next.role_buf = frame[7:0];
                end else if (frame[14:8] == ADDR_UPDATE && frame[UPDATE_BIT]) begin
                    s_next.sel_act = s_reg.sel_buf;
                    s_next.role_act = s_reg.role_buf;
                    s_next.cnt_act = s_reg.cnt_buf;
                    s_next.cfg_act = s_reg.cfg_buf;
                end else if (frame[14:8] >= ADDR_DIV_FIRST && frame[14:8] <= ADDR_CFG_LAST) begin
                    if (frame[8]) begin
                        s_next.cfg_buf[3'((frame[14:8] - ADDR_CFG_FIRST) >> 1)] = frame[7:0];
                    end else begin
                        s_next.cnt_buf[3'((frame[14:8] - ADDR_DIV_FIRST) >> 1)] = frame[7:0];
                    end
                end
            end
        end
    end

    // State register; hard reset loads defaults into buffer and active copies alike.
    always_ff @(posedge i_core_clk or negedge hard_rst_n) begin
        if (!hard_rst_n) begin
            s_reg <= '0;
            s_reg.sel_buf <= INPUT_SEL_RST;
            s_reg.sel_act <= INPUT_SEL_RST;
            s_reg.role_buf <= ROLE_RST;
            s_reg.role_act <= ROLE_RST;
            s_reg.cnt_buf <= {N_OUT{DIV_COUNTS_RST}};
            s_reg.cnt_act <= {N_OUT{DIV_COUNTS_RST}};
            s_reg.cfg_buf <= {N_OUT{DIV_CFG_RST}};
            s_reg.cfg_act <= {N_OUT{DIV_CFG_RST}};
        end else begin
            s_reg <= s_next;
        end
    end

    // ============================================================
    // Dividers, one per output.
    // ============================================================
    generate
        for (genvar i = 0; i < N_OUT; i++) begin : g_ch
            cdsc_ch_if ch_if ();
            // Alignment reaches the dividers in every role.
            assign ch_if.tick = tick;
            assign ch_if.fast_level = fast_level;
            assign ch_if.align_low = !s_reg.pin_sync[1];
            assign ch_if.align_rise = align_rise;
            assign ch_if.high_field = s_reg.cnt_act[i][HIGH_FIELD_LSB +: 4];
            assign ch_if.low_field = s_reg.cnt_act[i][LOW_FIELD_LSB +: 4];
            assign ch_if.phase = s_reg.cfg_act[i][CFG_PHASE_LSB +: 4];
            assign ch_if.bypass = s_reg.cfg_act[i][CFG_BYPASS_BIT];
            assign ch_if.noalign = s_reg.cfg_act[i][CFG_NOALIGN_BIT];
            assign ch_if.start_high = s_reg.cfg_act[i][CFG_START_HIGH_BIT];
            assign ch_if.pd = s_reg.cfg_act[i][CFG_PD_BIT];
            assign div_out[i] = ch_if.out;
            // Ratios 2 to 32 come from the counter, ratio 1 only from bypass.
            cdsc_divider u_div (
                .i_core_clk(i_core_clk),
                .i_pd_rst_n(pd_rst_n),
                .ch(ch_if.div)
            );
        end
    endgenerate

    // Outputs straight from flip-flops.
    assign o_clk_out = s_reg.clk_out;
    assign o_scp_sdo = s_reg.rd_shift[7];
    assign o_scp_sdo_oe = s_reg.sdo_oe;
    assign o_powered_down = s_reg.pd_flag;

    // ============================================================
    // Checks.
    // ============================================================
    property p_align_role_safe;
        @(posedge i_core_clk) disable iff (!i_rstn)
        role == ROLE_ALIGN |-> hard_rst_n && pd_rst_n;
    endproperty
    a_align_role_safe: assert property (p_align_role_safe) else $error("align role resets");

    property p_align_pulse;
        @(posedge i_core_clk) disable iff (!hard_rst_n)
        align_rise |=> !align_rise ##1 s_reg.pin_sync[2];
    endproperty
    a_align_pulse: assert property (p_align_pulse) else $error("alignment edge not single");

    property p_pd_keeps;
        @(posedge i_core_clk) disable iff (!hard_rst_n)
        !pd_rst_n |=> s_reg.cnt_act == $past(s_reg.cnt_act) && s_reg.role_act == $past(s_reg.role_act);
    endproperty
    a_pd_keeps: assert property (p_pd_keeps) else $error("power-down lost settings");

endmodule // cdsc_top

// ---- rtl/cdsc_pkg.sv ----
// ============================================================
// Shared constants of the clock divider and alignment control.
// ============================================================
package cdsc_pkg;

    // Number of output channels, each with its own divider.
    localparam int NUM_OUT = 8;

    // Serial frame layout: one direction bit, seven address bits, eight data bits.
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] ADDR_LAST_BIT = 5'h07;
    localparam logic [4:0] DATA_LAST_BIT = 5'h0f;
    localparam logic [4:0] FRAME_DONE = 5'h10;

    // ============================================================
    // Register offsets.
    // ============================================================
    localparam logic [6:0] ADDR_INPUT_SEL = 7'h45;
    localparam logic [6:0] ADDR_DIV_FIRST = 7'h48;
    localparam logic [6:0] ADDR_DIV_LAST = 7'h56;
    localparam logic [6:0] ADDR_CFG_FIRST = 7'h49;
    localparam logic [6:0] ADDR_CFG_LAST = 7'h57;
    localparam logic [6:0] ADDR_ROLE = 7'h58;
    localparam logic [6:0] ADDR_UPDATE = 7'h5a;
    localparam logic [6:0] ADDR_STATUS = 7'h5b;

    // ============================================================
    // Field positions.
    // ============================================================
    localparam int SEL_FIRST_BIT = 0;
    localparam int HIGH_FIELD_LSB = 0;
    localparam int LOW_FIELD_LSB = 4;
    localparam int ROLE_LSB = 5;
    localparam int UPDATE_BIT = 0;
    localparam int CFG_BYPASS_BIT = 0;
    localparam int CFG_NOALIGN_BIT = 1;
    localparam int CFG_START_HIGH_BIT = 2;
    localparam int CFG_PD_BIT = 3;
    localparam int CFG_PHASE_LSB = 4;

    // Pin role codes.
    localparam logic [1:0] ROLE_HARD_RESET = 2'b00;
    localparam logic [1:0] ROLE_ALIGN = 2'b01;
    localparam logic [1:0] ROLE_POWERDOWN = 2'b11;

    // ============================================================
    // Reset values.
    // ============================================================
    localparam logic [7:0] INPUT_SEL_RST = 8'h01;
    localparam logic [7:0] DIV_COUNTS_RST = 8'h00;
    localparam logic [7:0] DIV_CFG_RST = 8'h00;
    localparam logic [7:0] ROLE_RST = 8'h00;

endpackage

// ---- rtl/cdsc_ch_if.sv ----
`timescale 1ns/1ps
// ============================================================
// Control and result of one output divider.
// ============================================================
interface cdsc_ch_if;
    logic tick; // One-cycle pulse per rising edge of the selected fast input.
    logic fast_level; // Synchronised level of the selected fast input.
    logic align_low; // Alignment pin seen low.
    logic align_rise; // One-cycle pulse on the alignment rising edge.
    logic [3:0] high_field; // High time minus one, in fast cycles.
    logic [3:0] low_field; // Low time minus one, in fast cycles.
    logic [3:0] phase; // Wait after alignment minus one, in fast cycles.
    logic bypass; // Divide by one.
    logic noalign; // Channel ignores alignment.
    logic start_high; // Level held while alignment is low.
    logic pd; // Output powered down.
    logic out; // Divider output.

    modport ctrl (output tick, fast_level, align_low, align_rise, high_field, low_field,
                  phase, bypass, noalign, start_high, pd, input out);
    modport div (input tick, fast_level, align_low, align_rise, high_field, low_field,
                 phase, bypass, noalign, start_high, pd, output out);
endinterface

// ---- rtl/cdsc_divider.sv ----
`timescale 1ns/1ps
// ============================================================
// One output divider with alignment hold and phase offset.
// ============================================================
module cdsc_divider
    import cdsc_pkg::*;
(
    // Clock and power-down reset.
    input wire logic i_core_clk,
    input wire logic i_pd_rst_n,
    // Channel carrier.
    cdsc_ch_if.div ch
);

    // All divider state.
    typedef struct packed {
        logic out;
        logic waiting;
        logic [3:0] cnt;
        logic [3:0] phase_cnt;
    } cdsc_div_state_t;

    cdsc_div_state_t d_reg; // Registered state.
    cdsc_div_state_t d_next; // Next state.
    logic affected; // Channel takes part in alignment.

    assign affected = !ch.pd && !ch.noalign && !ch.bypass;
    assign ch.out = d_reg.out;

    // Next-state logic; power-down wins, then bypass, then alignment, then counting.
    always_comb begin
        d_next = d_reg;
        if (ch.pd) begin
            d_next.out = 1'b0;
            d_next.waiting = 1'b0;
            d_next.cnt = 4'h0;
        end else if (ch.bypass) begin
            // The counter stays parked to save power; the input passes at divide by one.
            d_next.out = ch.fast_level;
            d_next.cnt = 4'h0;
            d_next.waiting = 1'b0;
        end else if (affected && ch.align_low) begin
            d_next.out = ch.start_high;
            d_next.cnt = 4'h0;
            d_next.waiting = 1'b1;
            d_next.phase_cnt = ch.phase;
        end else if (affected && ch.align_rise) begin
            d_next.waiting = 1'b1;
            d_next.phase_cnt = ch.phase;
        end else if (ch.tick) begin
            if (d_reg.waiting) begin
                // The wait lasts phase plus one fast cycles.
                if (d_reg.phase_cnt == 4'h0) begin
                    d_next.waiting = 1'b0;
                end else begin
                    d_next.phase_cnt = d_reg.phase_cnt - 4'h1;
                end
            end else if (d_reg.cnt == (d_reg.out ? ch.high_field : ch.low_field)) begin
                d_next.out = !d_reg.out;
                d_next.cnt = 4'h0;
            end else begin
                d_next.cnt = d_reg.cnt + 4'h1;
            end
        end
    end

    // State register, cleared by hard reset or power-down.
    always_ff @(posedge i_core_clk or negedge i_pd_rst_n) begin
        if (!i_pd_rst_n) begin
            d_reg <= '0;
        end else begin
            d_reg <= d_next;
        end
    end

    // ============================================================
    // Checks.
    // ============================================================
    logic [4:0] run_ticks; // Fast cycles since the last counted toggle.
    logic run_ok; // A full segment is being measured.

    // Helper that measures segment lengths for the duty checks.
    always_ff @(posedge i_core_clk or negedge i_pd_rst_n) begin
        if (!i_pd_rst_n) begin
            run_ticks <= 5'h00;
            run_ok <= 1'b0;
        end else if (ch.pd || ch.bypass || ch.align_low || ch.align_rise
                     || $changed(ch.high_field) || $changed(ch.low_field)) begin
            // A count change in mid-segment leaves that segment with no defined length.
            run_ticks <= 5'h00;
            run_ok <= 1'b0;
        end else if (d_next.out != d_reg.out) begin
            run_ticks <= 5'h00;
            run_ok <= 1'b1;
        end else if (ch.tick && !d_reg.waiting) begin
            run_ticks <= run_ticks + 5'h01;
        end
    end

    sequence s_align_held;
        affected && ch.align_low;
    endsequence

    property p_hold_level;
        @(posedge i_core_clk) disable iff (!i_pd_rst_n)
        s_align_held |=> (d_reg.out == $past(ch.start_high)) && d_reg.waiting;
    endproperty
    a_hold_level: assert property (p_hold_level) else $error("held level wrong");

    property p_phase_load;
        @(posedge i_core_clk) disable iff (!i_pd_rst_n)
        affected && ch.align_rise |=> d_reg.waiting && (d_reg.phase_cnt == $past(ch.phase));
    endproperty
    a_phase_load: assert property (p_phase_load) else $error("phase wait not loaded");

    property p_bypass_pass;
        @(posedge i_core_clk) disable iff (!i_pd_rst_n)
        ch.bypass && !ch.pd |=> d_reg.out == $past(ch.fast_level) && d_reg.cnt == 4'h0;
    endproperty
    a_bypass_pass: assert property (p_bypass_pass) else $error("bypass not passing");

    property p_high_len;
        @(posedge i_core_clk) disable iff (!i_pd_rst_n)
        run_ok && d_reg.out && !d_next.out && !ch.pd && !ch.bypass
            && $stable(ch.high_field) && $stable(ch.low_field)
            |-> (run_ticks + 5'h01) == {1'b0, ch.high_field} + 5'h01;
    endproperty
    a_high_len: assert property (p_high_len) else $error("high time wrong");

    property p_low_len;
        @(posedge i_core_clk) disable iff (!i_pd_rst_n)
        run_ok && !d_reg.out && d_next.out && !ch.pd && !ch.bypass
            && $stable(ch.high_field) && $stable(ch.low_field)
            |-> (run_ticks + 5'h01) == {1'b0, ch.low_field} + 5'h01;
    endproperty
    a_low_len: assert property (p_low_len) else $error("low time wrong");

    property p_pd_quiet;
        @(posedge i_core_clk) disable iff (!i_pd_rst_n)
        ch.pd [*2] |-> !d_reg.out;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("powered-down output moves");

endmodule // cdsc_divider

// ---- tb/cdsc_ctrl_model.sv ----
`timescale 1ns/1ps
// ============================================================
// External controller: serial frames and the function pin.
// ============================================================
module cdsc_ctrl_model (
    // Pacing clock and serial read data.
    input wire logic i_core_clk,
    input wire logic i_sdo,
    // Serial port and pin drives.
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdi,
    output logic o_pin
);
    // Idle: deselected, serial clock parked low, pin released high.
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b0;
        o_pin = 1'b1;
    end
    // Serial phases of six core cycles, above the four-cycle sampler floor.
    task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] d,
                         output logic [7:0] q);
        logic [15:0] sh;
        sh = {rd, a, d};
        q = 8'h00;
        // Select drops just after a core edge, never in the edge's own time step.
        @(posedge i_core_clk);
        #2 o_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            o_sdi = sh[i];
            repeat (6) @(posedge i_core_clk);
            #2 o_sclk = 1'b1;
            if (i < 8) q[i] = i_sdo;
            repeat (6) @(posedge i_core_clk);
            #2 o_sclk = 1'b0;
        end
        #0 o_sdi = ~o_sdi;
        repeat (6) @(posedge i_core_clk);
        #2 o_cs_n = 1'b1;
        repeat (6) @(posedge i_core_clk);
    endtask
    // Pin level changes just after a core edge.
    task automatic pin(input logic v);
        @(posedge i_core_clk);
        #2 o_pin = v;
    endtask
endmodule // cdsc_ctrl_model

// ---- tb/tb_clock_divider_sync_control.sv ----
`timescale 1ns/1ps
// ============================================================
// Bench: register setup, divider timing and pin roles.
// ============================================================
module tb_clock_divider_sync_control
    import cdsc_pkg::*;
;
    logic clk = 1'b0, rstn = 1'b0, f1 = 1'b0, f2 = 1'b0, use_two = 1'b0;
    logic sdo, sdo_oe, pd, sclk, cs_n, sdi, pin, oe_seen;
    logic [7:0] out, r, cnt;
    logic [15:0] seen, exp_v;
    logic [15:0] exp_q[$];
    string what;
    event got;
    int num_errors = 0, checked = 0, c;

    always #12.5 clk = ~clk;
    // Fast inputs: ticks every 8 and 12 core cycles, slow enough for the sampler.
    always begin
        repeat (4) @(posedge clk);
        #2 f1 = ~f1;
    end
    // The second input stays still while unused so it cannot disturb the first; the first always toggles.
    always begin
        repeat (6) @(posedge clk);
        #2 f2 = use_two ? ~f2 : f2;
    end

    cdsc_top DUT (.i_core_clk(clk), .i_rstn(rstn), .i_function_pin(pin),
        .i_fast_input_one(f1), .i_fast_input_two(f2), .i_scp_sclk(sclk),
        .i_scp_cs_n(cs_n), .i_scp_sdi(sdi), .o_scp_sdo(sdo), .o_scp_sdo_oe(sdo_oe),
        .o_clk_out(out), .o_powered_down(pd));
    cdsc_ctrl_model ctrl (.i_core_clk(clk), .i_sdo(sdo), .o_sclk(sclk), .o_cs_n(cs_n),
        .o_sdi(sdi), .o_pin(pin));

    // Remembers whether the read data line was driven during a frame.
    always @(posedge clk) begin
        if (sdo_oe) begin
            oe_seen <= 1'b1;
        end
    end

    // Compares each observed result with the oldest expectation.
    always @(got) begin
        exp_v = exp_q.pop_front();
        checked++;
        if (exp_v !== seen) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp_v, seen);
        end
    end
    task automatic note(input string n, input logic [15:0] e, input logic [15:0] v);
        exp_q.push_back(e);
        what = n;
        seen = v;
        ->got;
        #1;
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Counts falling edges until an output reaches a level; bounded.
    task automatic wait_lvl(input int ch, input logic v);
        c = 0;
        while (out[ch] !== v) begin
            @(negedge clk);
            c++;
            if (c > 1000) begin
                num_errors++;
                stop_test();
            end
        end
    endtask
    // Measures one high and one low stretch in core cycles.
    task automatic period(input int ch, input int tk, input logic [7:0] k);
        wait_lvl(ch, 1'b0);
        wait_lvl(ch, 1'b1);
        wait_lvl(ch, 1'b0);
        note("high time", 16'((k[3:0] + 1) * tk), 16'(c));
        wait_lvl(ch, 1'b1);
        note("low time", 16'((k[7:4] + 1) * tk), 16'(c));
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        oe_seen = 1'b0;
        ctrl.frame(1'b1, a, 8'h00, r);
        note("register", {8'h00, e}, {8'h00, r});
        note("drive enable", 16'h0002, {14'h0000, oe_seen, sdo_oe});
    endtask
    // Every write is followed by the copy into the active registers.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        ctrl.frame(1'b0, a, d, r);
        ctrl.frame(1'b0, ADDR_UPDATE, 8'h01, r);
    endtask

    initial begin
        void'($urandom(80231));
        cnt = 8'($urandom_range(255));
        repeat (10) @(posedge clk);
        #2 rstn = 1'b1;
        repeat (5) @(posedge clk);
        rd(ADDR_INPUT_SEL, INPUT_SEL_RST);
        rd(ADDR_ROLE, ROLE_RST);
        rd(ADDR_DIV_LAST, DIV_COUNTS_RST);
        rd(7'h00, 8'h00);
        wr(ADDR_DIV_FIRST, cnt);
        rd(ADDR_DIV_FIRST, cnt);
        period(0, 8, cnt);
        wr(ADDR_CFG_FIRST, 8'h01);
        period(0, 4, 8'h00);
        wr(ADDR_CFG_FIRST, 8'h00);
        use_two = 1'b1;
        wr(ADDR_INPUT_SEL, 8'h00);
        period(0, 12, cnt);
        use_two = 1'b0;
        wr(ADDR_INPUT_SEL, 8'h01);
        // Alignment role: two channels, start high, phase 0 and 2.
        wr(ADDR_ROLE, 8'h20);
        wr(ADDR_DIV_FIRST, 8'h33);
        wr(7'h4a, 8'h33);
        wr(ADDR_CFG_FIRST, 8'h04);
        wr(7'h4b, 8'h24);
        ctrl.pin(1'b0);
        repeat (40) @(negedge clk);
        note("held levels", 16'h0003, {14'h0000, out[1:0]});
        note("power flag", 16'h0000, {15'h0000, pd});
        ctrl.pin(1'b1);
        wait_lvl(0, 1'b0);
        wait_lvl(1, 1'b0);
        note("phase gap", 16'h0010, 16'(c));
        // Power-down role keeps settings; hard reset role restores defaults.
        wr(ADDR_ROLE, 8'h60);
        ctrl.pin(1'b0);
        repeat (6) @(negedge clk);
        note("powered down", 16'h0001, {15'h0000, pd});
        ctrl.pin(1'b1);
        repeat (6) @(negedge clk);
        rd(ADDR_DIV_FIRST, 8'h33);
        wr(ADDR_ROLE, 8'h00);
        ctrl.pin(1'b0);
        repeat (6) @(negedge clk);
        ctrl.pin(1'b1);
        repeat (6) @(negedge clk);
        rd(ADDR_DIV_FIRST, DIV_COUNTS_RST);
        // A second reset on the reset input in mid-run restores the defaults too.
        wr(ADDR_INPUT_SEL, 8'h00);
        @(posedge clk);
        #2 rstn = 1'b0;
        @(negedge clk);
        note("reset outputs", 16'h0000, {out, 7'h00, pd});
        repeat (3) @(posedge clk);
        #2 rstn = 1'b1;
        repeat (3) @(posedge clk);
        rd(ADDR_INPUT_SEL, INPUT_SEL_RST);
        stop_test();
    end
endmodule // tb_clock_divider_sync_control
